//--- design/tasm_top.sv
// Status and mask logic of a seven-channel temperature monitor.
// Assumes the serial engine presents byte reads and writes as one-cycle strobes,
// and the converter presents temperature and the channel's limits at conv end.
//
// Overview of operation
// - Config 3 bits 3..5 mask channels 4..6 overtemp
// - Config 3 bit 0 masks channel 1; others reserved
// - Status 1 bit 6: local over alert limit
// - Status 1 bits 0..5: remote 1..6 over limit
// - Config 1 bit 3 enables channel 1 cancellation
// - Cancellation adds 125 ms to channel 1 slot
// - Faulted diode flagged in status and skipped
// - Status 2 read clears bits, not overtemp output
// - Condition ends only more than 4 degrees below threshold
// - Config 2 bits 0..6 mask channel alerts
`timescale 1ns/100ps
module tasm_top
   import tasm_pkg::*;
#(
   parameter int MS_CYCLES_P = MS_CYCLES
)
(
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic reg_rack,
   input wire logic [7:0] meas_temp,
   input wire logic [7:0] alert_limit,
   input wire logic [7:0] overtemp_shutdown_out_limit,
   input wire logic [5:0] diode_fault_in,
   output logic [2:0] meas_chan,
   output logic ch1_rcan_en,
   input wire logic alert_n_in,
   output logic alert_n_out,
   output logic alert_n_oe_n,
   input wire logic overtemp_shutdown_in,
   output logic overtemp_shutdown_out,
   output logic overtemp_shutdown_oe_n
);
   logic [7:0] cfg1_q;
   logic [6:0] cfg2_q;
   logic [5:0] cfg3_q;
   logic [6:0] st1_q;
   logic [6:0] st1_d;
   logic [6:0] st2_q;
   logic [6:0] st2_d;
   logic [6:0] st3_q;
   logic [6:0] alert_cond_q;
   logic [6:0] ovt_cond_q;
   logic [6:0] skip;
   logic soft_rst_q;
   logic rst_all;
   logic conv_done;
   logic [2:0] done_chan;
   logic rcan_active;
   logic alert_hit;
   logic ovt_hit;
   logic rd_st1;
   logic rd_st2;

   function automatic logic cond_next(input logic cur, input logic [7:0] t,
                                      input logic [7:0] lim);
      if (cur)
         return !({1'b0, t} + HYST_DEGC < {1'b0, lim});
      else
         return t > lim;
   endfunction

   assign rst_all = srst || soft_rst_q;
   assign skip = {1'b0, diode_fault_in};
   assign rd_st1 = reg_rd && reg_addr == ADDR_ST1;
   assign rd_st2 = reg_rd && reg_addr == ADDR_ST2;

   tasm_conv_seq #(
      .MS_CYCLES_P(MS_CYCLES_P)
   ) u_seq (
      .sys_clk(sys_clk),
      .srst(rst_all),
      .run(!cfg1_q[CFG1_STOP_BIT]),
      .rcan_en(cfg1_q[CFG1_RCAN_BIT]),
      .skip(skip),
      .conv_done(conv_done),
      .done_chan(done_chan),
      .conv_chan(meas_chan),
      .rcan_active(rcan_active)
   );

   // ----------------------------------------------------------------
   // Configuration registers
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      // Self-clearing reset bit restores the reset state next cycle
      soft_rst_q <= !srst && reg_wr && reg_addr == ADDR_CFG1 && reg_wdata[CFG1_POR_BIT];
      if (rst_all)
      begin
         cfg1_q <= CFG_RESET;
         cfg2_q <= CFG_RESET[6:0];
         cfg3_q <= CFG_RESET[5:0];
      end
      else if (reg_wr)
      begin
         case (reg_addr)
            ADDR_CFG1: cfg1_q <= reg_wdata & CFG1_WMASK;
            ADDR_CFG2: cfg2_q <= reg_wdata[6:0] & CFG2_WMASK[6:0];
            ADDR_CFG3: cfg3_q <= reg_wdata[5:0] & CFG3_WMASK[5:0];
            default: cfg1_q <= cfg1_q;
         endcase
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst_all)
         ch1_rcan_en <= 1'b0;
      else
         ch1_rcan_en <= rcan_active;
   end

   // ----------------------------------------------------------------
   // Conditions with hysteresis
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (rst_all)
      begin
         alert_cond_q <= STATUS_RESET;
         ovt_cond_q <= STATUS_RESET;
      end
      else if (conv_done && !skip[done_chan])
      begin
         alert_cond_q[done_chan] <= cond_next(alert_cond_q[done_chan], meas_temp,
                                              alert_limit);
         if (OVT_CHANS[done_chan])
            ovt_cond_q[done_chan] <= cond_next(ovt_cond_q[done_chan], meas_temp, overtemp_shutdown_out_limit);
      end
   end

   // ----------------------------------------------------------------
   // Status registers: a set in the read cycle survives the clear
   // ----------------------------------------------------------------
   always_comb
   begin
      st1_d = rd_st1 ? STATUS_RESET : st1_q;
      st2_d = rd_st2 ? STATUS_RESET : st2_q;
      if (conv_done && !skip[done_chan])
      begin
         st1_d[done_chan] = st1_d[done_chan] ||
            cond_next(alert_cond_q[done_chan], meas_temp, alert_limit);
         if (OVT_CHANS[done_chan])
            st2_d[done_chan] = st2_d[done_chan] ||
               cond_next(ovt_cond_q[done_chan], meas_temp, overtemp_shutdown_out_limit);
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst_all)
      begin
         st1_q <= STATUS_RESET;
         st2_q <= STATUS_RESET;
         st3_q <= STATUS_RESET;
      end
      else
      begin
         st1_q <= st1_d;
         st2_q <= st2_d;
         st3_q <= {diode_fault_in, 1'b0};
      end
   end

   // ----------------------------------------------------------------
   // Open-drain outputs, enable low while pulling the pin low
   // ----------------------------------------------------------------
   assign alert_hit = |(st1_q & ~cfg2_q);
   // The live condition keeps the shutdown pin held after a status read
   assign ovt_hit = |((st2_q | ovt_cond_q) & ~{1'b0, cfg3_q} & OVT_CHANS);

   always_ff @(posedge sys_clk)
   begin
      alert_n_out <= 1'b0;
      overtemp_shutdown_out <= 1'b0;
      if (rst_all)
      begin
         alert_n_oe_n <= 1'b1;
         overtemp_shutdown_oe_n <= 1'b1;
      end
      else
      begin
         alert_n_oe_n <= !alert_hit;
         overtemp_shutdown_oe_n <= !ovt_hit;
      end
   end

   // ----------------------------------------------------------------
   // Read port: data one cycle after the strobe, unmapped reads as zero
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         reg_rdata <= 8'h00;
         reg_rack <= 1'b0;
      end
      else
      begin
         reg_rack <= reg_rd;
         case (reg_addr)
            ADDR_CFG1: reg_rdata <= cfg1_q;
            ADDR_CFG2: reg_rdata <= {1'b0, cfg2_q};
            ADDR_CFG3: reg_rdata <= {2'b00, cfg3_q};
            ADDR_ST1: reg_rdata <= {1'b0, st1_q};
            ADDR_ST2: reg_rdata <= {1'b0, st2_q};
            ADDR_ST3: reg_rdata <= {1'b0, st3_q};
            default: reg_rdata <= 8'h00;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   property p_cfg3_write;
      @(posedge sys_clk) disable iff (rst_all)
      (reg_wr && reg_addr == ADDR_CFG3) |=> cfg3_q == ($past(reg_wdata[5:0]) & 6'h39);
   endproperty
   a_cfg3_write: assert property (p_cfg3_write) else $error("config 3 write wrong");

   property p_ovt_masked;
      @(posedge sys_clk) disable iff (rst_all)
      (((st2_q | ovt_cond_q) & ~{1'b0, cfg3_q} & OVT_CHANS) == 7'h00) |=> overtemp_shutdown_oe_n;
   endproperty
   a_ovt_masked: assert property (p_ovt_masked) else $error("masked overtemp drove pin");

   property p_local_alert;
      @(posedge sys_clk) disable iff (rst_all)
      (conv_done && done_chan == LOCAL_CHAN && meas_temp > alert_limit) |=> st1_q[6];
   endproperty
   a_local_alert: assert property (p_local_alert) else $error("local alert not set");

   property p_remote_alert;
      @(posedge sys_clk) disable iff (rst_all)
      (conv_done && done_chan < LOCAL_CHAN && !skip[done_chan] && meas_temp > alert_limit)
         |=> st1_q[$past(done_chan)];
   endproperty
   a_remote_alert: assert property (p_remote_alert) else $error("remote alert not set");

   sequence s_cleared_read;
      rd_st1 && !conv_done ##1 st1_q == STATUS_RESET;
   endsequence
   property p_read_clears;
      @(posedge sys_clk) disable iff (rst_all)
      (rd_st1 && !conv_done && (cfg2_q == 7'h00)) |=> (st1_q == STATUS_RESET) ##1 alert_n_oe_n;
   endproperty
   a_read_clears: assert property (p_read_clears) else $error("status 1 read did not clear");

   property p_ovt_held;
      @(posedge sys_clk) disable iff (rst_all)
      (rd_st2 && |(ovt_cond_q & ~{1'b0, cfg3_q} & OVT_CHANS) && !conv_done)
         |=> ##1 !overtemp_shutdown_oe_n;
   endproperty
   a_ovt_held: assert property (p_ovt_held) else $error("status 2 read released pin");

   property p_st2_sticky;
      @(posedge sys_clk) disable iff (rst_all)
      !rd_st2 |=> (st2_q & $past(st2_q)) == $past(st2_q);
   endproperty
   a_st2_sticky: assert property (p_st2_sticky) else $error("status 2 bit lost");

   property p_hyst_hold;
      @(posedge sys_clk) disable iff (rst_all)
      (conv_done && !skip[done_chan] && alert_cond_q[done_chan] &&
       ({1'b0, meas_temp} + HYST_DEGC >= {1'b0, alert_limit}))
         |=> alert_cond_q[$past(done_chan)];
   endproperty
   a_hyst_hold: assert property (p_hyst_hold) else $error("condition ended inside band");

   property p_alert_pin;
      @(posedge sys_clk) disable iff (rst_all)
      ((st1_q & ~cfg2_q) != 7'h00) |=> !alert_n_oe_n;
   endproperty
   a_alert_pin: assert property (p_alert_pin) else $error("unmasked alert not driven");
endmodule

//--- design/tasm_pkg.sv
// Shared constants and types of the thermal alarm status and mask block.
// Assumes one 125 MHz clock; all counts derive from the figures below.
package tasm_pkg;
   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_CFG1 = 8'h41;
   localparam logic [7:0] ADDR_CFG2 = 8'h42;
   localparam logic [7:0] ADDR_CFG3 = 8'h43;
   localparam logic [7:0] ADDR_ST1 = 8'h44;
   localparam logic [7:0] ADDR_ST2 = 8'h45;
   localparam logic [7:0] ADDR_ST3 = 8'h46;
   // ----------------------------------------------------------------
   // Field layout and reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] CFG1_WMASK = 8'hb8;
   localparam logic [7:0] CFG2_WMASK = 8'h7f;
   localparam logic [7:0] CFG3_WMASK = 8'h39;
   localparam logic [6:0] OVT_CHANS = 7'h39;
   localparam int CFG1_RCAN_BIT = 3;
   localparam int CFG1_POR_BIT = 6;
   localparam int CFG1_STOP_BIT = 7;
   localparam logic [2:0] LOCAL_CHAN = 3'h6;
   localparam logic [2:0] CH1_CHAN = 3'h0;
   localparam logic [7:0] CFG_RESET = 8'h00;
   localparam logic [6:0] STATUS_RESET = 7'h00;
   localparam logic [8:0] HYST_DEGC = 9'h004;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_HZ = 125_000_000;
   localparam int MS_PER_S = 1000;
   localparam int MS_CYCLES = CLK_HZ / MS_PER_S;
   localparam int SLOT_MS = 125;
   localparam int RCAN_EXTRA_MS = 125;
   typedef enum logic [0:0] {
      TASM_IDLE = 1'b0,
      TASM_CONV = 1'b1
   } tasm_state_type;
endpackage

//--- design/tasm_conv_seq.sv
// Conversion slot sequencer: walks the seven channels, skips faulted ones,
// and stretches the channel 1 slot while resistance cancellation is enabled.
// Assumes run and skip are synchronous to sys_clk.
`timescale 1ns/100ps
module tasm_conv_seq
   import tasm_pkg::*;
#(
   parameter int MS_CYCLES_P = MS_CYCLES
)
(
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic run,
   input wire logic rcan_en,
   input wire logic [6:0] skip,
   output logic conv_done,
   output logic [2:0] done_chan,
   output logic [2:0] conv_chan,
   output logic rcan_active
);
   tasm_state_type state_q;
   logic [31:0] ms_cnt_q;
   logic ms_tick_q;
   logic [7:0] slot_ms_q;
   logic [7:0] slot_len;

   function automatic logic [2:0] next_chan(input logic [2:0] c, input logic [6:0] sk);
      logic [2:0] n;
      logic found;
      n = c;
      found = 1'b0;
      for (int i = 0; i < 7; i++)
      begin
         if (!found)
         begin
            n = (n == LOCAL_CHAN) ? 3'h0 : n + 3'h1;
            found = !sk[n];
         end
      end
      return found ? n : LOCAL_CHAN;
   endfunction

   // ----------------------------------------------------------------
   // Millisecond tick
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (srst || ms_cnt_q == 32'(MS_CYCLES_P - 1))
         ms_cnt_q <= 32'h0;
      else
         ms_cnt_q <= ms_cnt_q + 32'h1;
      ms_tick_q <= !srst && ms_cnt_q == 32'(MS_CYCLES_P - 1);
   end

   // Channel 1 gets a longer slot when cancellation is enabled
   assign slot_len = (conv_chan == CH1_CHAN && rcan_en) ?
                     8'(SLOT_MS + RCAN_EXTRA_MS) : 8'(SLOT_MS);

   // ----------------------------------------------------------------
   // Slot sequencing
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      conv_done <= 1'b0;
      if (srst)
      begin
         state_q <= TASM_IDLE;
         slot_ms_q <= 8'h0;
         conv_chan <= 3'h0;
         done_chan <= 3'h0;
      end
      else
      begin
         case (state_q)
            TASM_IDLE:
            begin
               slot_ms_q <= 8'h0;
               if (run)
               begin
                  state_q <= TASM_CONV;
                  if (skip[conv_chan])
                     conv_chan <= next_chan(conv_chan, skip);
               end
            end
            TASM_CONV:
            begin
               if (!run)
                  state_q <= TASM_IDLE;
               else if (ms_tick_q)
               begin
                  if (slot_ms_q + 8'h1 >= slot_len)
                  begin
                     slot_ms_q <= 8'h0;
                     conv_done <= 1'b1;
                     done_chan <= conv_chan;
                     conv_chan <= next_chan(conv_chan, skip);
                  end
                  else
                     slot_ms_q <= slot_ms_q + 8'h1;
               end
            end
            default: state_q <= TASM_IDLE;
         endcase
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (srst)
         rcan_active <= 1'b0;
      else
         rcan_active <= rcan_en && conv_chan == CH1_CHAN && state_q == TASM_CONV;
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   logic [7:0] tick_seen_q;
   always_ff @(posedge sys_clk)
   begin
      if (srst || conv_done || state_q == TASM_IDLE)
         tick_seen_q <= 8'h0;
      else if (ms_tick_q)
         tick_seen_q <= tick_seen_q + 8'h1;
   end

   property p_rcan_slot;
      @(posedge sys_clk) disable iff (srst)
      (conv_done && done_chan == CH1_CHAN && rcan_en && $past(rcan_en))
         |-> tick_seen_q == 8'(SLOT_MS + RCAN_EXTRA_MS);
   endproperty
   a_rcan_slot: assert property (p_rcan_slot) else $error("channel 1 slot length wrong");

   property p_no_faulted_done;
      @(posedge sys_clk) disable iff (srst)
      (state_q == TASM_CONV && $stable(skip) && $stable(conv_chan))
         |-> !skip[conv_chan] || conv_chan == LOCAL_CHAN;
   endproperty
   a_no_faulted_done: assert property (p_no_faulted_done) else $error("faulted channel converted");
endmodule

//--- tb/tasm_host.sv
// Host model: byte reads and writes over the block's strobe register port.
// Assumes it shares sys_clk with the block and is driven through its tasks.
`timescale 1ns/100ps
module tasm_host
   import tasm_pkg::*;
(
   input wire logic sys_clk,
   output logic [7:0] reg_addr,
   output logic reg_wr,
   output logic reg_rd,
   output logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_rack
);
   initial
   begin
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = 8'h00;
   end

   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      #1;
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge sys_clk);
      #1;
      reg_wr = 1'b0;
      // Stale data is inverted so a late sample cannot match by luck
      reg_wdata = ~d;
   endtask

   task rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      #1;
      reg_addr = a;
      reg_rd = 1'b1;
      @(posedge sys_clk);
      #1;
      reg_rd = 1'b0;
      // A missing answer yields unknown data, which no compare accepts
      d = (reg_rack === 1'b1) ? reg_rdata : 8'hxx;
   endtask

   task mask_unused(input logic [5:0] f);
      wr(ADDR_CFG2, {2'b00, f});
      wr(ADDR_CFG3, {2'b00, f[5:3], 2'b00, f[0]});
   endtask
endmodule

//--- tb/tasm_top_test.sv
// Self-checking bench of the thermal status and mask block.
// Assumes the host model tasm_host; the slot clock is shortened to 4 cycles per ms.
`timescale 1ns/100ps
module tasm_top_test
   import tasm_pkg::*;
;
   localparam int MSC = 4;
   logic sys_clk;
   logic srst;
   logic [7:0] reg_addr;
   logic reg_wr;
   logic reg_rd;
   logic [7:0] reg_wdata;
   logic [7:0] reg_rdata;
   logic reg_rack;
   logic [2:0] meas_chan;
   logic ch1_rcan_en;
   logic alert_n_out;
   logic alert_n_oe_n;
   logic overtemp_shutdown_out;
   logic overtemp_shutdown_oe_n;
   logic [5:0] fault_in;
   logic [7:0] temp_tab [0:6];
   logic [7:0] alim_tab [0:6];
   logic [7:0] olim_tab [0:6];
   logic skip_seen;
   int mismatches;
   int samples_checked;

   // ----------------------------------------------------------------
   // Converter and pin model
   // ----------------------------------------------------------------
   // Values follow the channel that just ended, since meas_chan advances with the end strobe
   logic [2:0] conv_src_q;
   always @(posedge sys_clk)
      conv_src_q <= meas_chan;
   wire logic [7:0] meas_temp = temp_tab[conv_src_q];
   wire logic [7:0] alert_limit = alim_tab[conv_src_q];
   wire logic [7:0] overtemp_shutdown_out_limit = olim_tab[conv_src_q];
   // Both pins are open drain with a pull-up
   wire logic alert_n_in = alert_n_oe_n ? 1'b1 : alert_n_out;
   wire logic ovt_in = overtemp_shutdown_oe_n ? 1'b1 : overtemp_shutdown_out;

   tasm_top #(.MS_CYCLES_P(MSC)) uut (.sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_rack(reg_rack), .meas_temp(meas_temp), .alert_limit(alert_limit),
      .overtemp_shutdown_out_limit(overtemp_shutdown_out_limit), .diode_fault_in(fault_in), .meas_chan(meas_chan),
      .ch1_rcan_en(ch1_rcan_en), .alert_n_in(alert_n_in), .alert_n_out(alert_n_out),
      .alert_n_oe_n(alert_n_oe_n), .overtemp_shutdown_in(ovt_in),
      .overtemp_shutdown_out(overtemp_shutdown_out),
      .overtemp_shutdown_oe_n(overtemp_shutdown_oe_n));

   tasm_host host (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rack(reg_rack));

   initial
   begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   always @(posedge sys_clk)
      if (srst === 1'b0 && meas_chan === 3'h2)
         skip_seen = 1'b1;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   task chk(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task wait_chan(input logic [2:0] c);
      int k;
      k = 0;
      while (meas_chan !== c && k < 5000)
      begin
         tick(1);
         k++;
      end
      if (k >= 5000)
      begin
         mismatches++;
         $display("BAD %0t channel %0d never reached", $time, c);
      end
   endtask

   task end_of_test;
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   initial
   begin
      repeat (60000) @(posedge sys_clk);
      mismatches++;
      $display("BAD %0t watchdog expired", $time);
      end_of_test;
   end

   // ----------------------------------------------------------------
   // Test sequence
   // ----------------------------------------------------------------
   initial
   begin
      logic [7:0] d;
      logic [7:0] mtab [0:4];
      int n0;
      int n1;
      mtab = '{8'h39, 8'h38, 8'h31, 8'h29, 8'h19};
      mismatches = 0;
      samples_checked = 0;
      skip_seen = 1'b0;
      srst = 1'b1;
      fault_in = 6'h04;
      foreach (temp_tab[i])
      begin
         temp_tab[i] = 8'h64;
         alim_tab[i] = 8'h5a;
         olim_tab[i] = 8'hc8;
      end
      repeat (20) @(posedge sys_clk);
      #1;
      srst = 1'b0;
      host.rd(ADDR_CFG3, d);
      chk(d, CFG_RESET);
      host.rd(ADDR_ST1, d);
      chk(d, 8'h00);
      host.rd(8'h00, d);
      chk(d, 8'h00);
      host.wr(ADDR_CFG3, 8'hff);
      host.rd(ADDR_CFG3, d);
      chk(d, 8'h39);
      host.wr(ADDR_CFG2, 8'hff);
      host.rd(ADDR_CFG2, d);
      chk(d, 8'h7f);
      host.mask_unused(fault_in);
      wait_chan(3'h6);
      wait_chan(3'h0);
      tick(3);
      chk({alert_n_oe_n, alert_n_out, overtemp_shutdown_out, overtemp_shutdown_oe_n}, 4'h1);
      host.rd(ADDR_ST1, d);
      chk(d, 8'h7b);
      host.rd(ADDR_ST3, d);
      chk(d, 8'h08);
      tick(2);
      chk(alert_n_oe_n, 1'b1);
      host.rd(ADDR_ST1, d);
      chk(d, 8'h00);
      wait_chan(3'h1);
      tick(3);
      chk(alert_n_oe_n, 1'b0);
      host.wr(ADDR_CFG2, 8'h7f);
      tick(3);
      chk(alert_n_oe_n, 1'b1);
      host.rd(ADDR_ST1, d);
      chk(d, 8'h01);
      // Only slot 1 is running, so every other limit may change now
      foreach (olim_tab[i])
         if (i != 1)
            olim_tab[i] = 8'h5a;
      wait_chan(3'h0);
      wait_chan(3'h1);
      tick(3);
      host.rd(ADDR_ST2, d);
      chk(d, 8'h39);
      tick(3);
      chk(overtemp_shutdown_oe_n, 1'b0);
      for (int i = 0; i < 5; i++)
      begin
         host.wr(ADDR_CFG3, mtab[i]);
         tick(3);
         chk(overtemp_shutdown_oe_n, i == 0);
      end
      host.wr(ADDR_CFG3, 8'h38);
      wait_chan(3'h1);
      temp_tab[0] = 8'h58;
      wait_chan(3'h0);
      wait_chan(3'h1);
      tick(3);
      host.rd(ADDR_ST2, d);
      tick(3);
      chk(overtemp_shutdown_oe_n, 1'b0);
      temp_tab[0] = 8'h55;
      wait_chan(3'h0);
      wait_chan(3'h1);
      tick(3);
      host.rd(ADDR_ST2, d);
      chk(d[0], 1'b0);
      tick(3);
      chk(overtemp_shutdown_oe_n, 1'b1);
      host.wr(ADDR_CFG1, 8'h08);
      host.rd(ADDR_CFG1, d);
      chk(d, 8'h08);
      wait_chan(3'h0);
      tick(10);
      chk(ch1_rcan_en, 1'b1);
      n0 = 10;
      while (meas_chan === 3'h0 && n0 < 3000)
      begin
         tick(1);
         n0++;
      end
      tick(10);
      chk(ch1_rcan_en, 1'b0);
      n1 = 10;
      while (meas_chan === 3'h1 && n1 < 3000)
      begin
         tick(1);
         n1++;
      end
      chk(16'(n0 - n1), 16'(RCAN_EXTRA_MS * MSC));
      // Self-clearing reset bit: registers, status and sequencer restart
      host.wr(ADDR_CFG1, 8'h48);
      host.rd(ADDR_CFG1, d);
      chk(d, CFG_RESET);
      chk(meas_chan, 3'h0);
      host.rd(ADDR_ST1, d);
      chk(d, 8'h00);
      chk(skip_seen, 1'b0);
      end_of_test;
   end
endmodule
